// ---- rtl/sscs_pkg.sv ----
// Purpose: Shared constants and types for the system clock source select.
// Assumes: 20 MHz bus clock, AXI4-Lite register access.
// Notes: Offsets are byte addresses of 32-bit words.
package sscs_pkg;
  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int XTAL_BIAS_NS = 100000;
  localparam int XTAL_BIAS_CYC = (XTAL_BIAS_NS + CLK_PERIOD_NS - 1) /
                                 CLK_PERIOD_NS;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] INT_CTRL_OFS = 8'h00;
  localparam logic [7:0] INT_CAL_OFS = 8'h04;
  localparam logic [7:0] EXT_CTRL_OFS = 8'h08;
  localparam logic [7:0] SRC_SEL_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  // Field positions
  localparam int DIV_LSB = 0;
  localparam int INT_EN_BIT = 2;
  localparam int DRIVE_LSB = 0;
  localparam int EXT_EN_BIT = 3;
  localparam int XVALID_BIT = 7;
  localparam int ACT_SRC_LSB = 0;
  localparam int ACT_DIV_LSB = 2;
  localparam int PEND_BIT = 4;
  // Reset values
  localparam logic [1:0] DIV_RESET = 2'h3;
  localparam logic INT_EN_RESET = 1'b1;
  localparam logic [7:0] FACTORY_TRIM_DEF = 8'h80;
  localparam logic [2:0] DRIVE_RESET = 3'h0;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SRC_SCALED = 2'b00,
    SRC_DIRECT = 2'b01,
    SRC_EXT = 2'b10
  } sscs_src_type;

  typedef struct packed {
    logic int_en;
    logic [1:0] internal_clock_divide_select;
    logic [7:0] int_trim;
    logic ext_en;
    logic [2:0] external_osc_drive_select;
  } sscs_osc_cfg_type;
endpackage

// ---- rtl/sscs_clock_select.sv ----
// Purpose: System clock source and divider selection with crystal check.
// Assumes: Oscillator edges arrive as one-cycle ticks synchronous to aclk.
// Notes on behaviour
// - After reset the system clock comes from the internal oscillator.
// - Sources: external oscillator, internal direct, internal scaled.
// - Divider field scales internal oscillator by one, two, four, eight.
// - Divider field resets to divide by eight.
// - Software enables internal oscillator and trims it separately.
// - Calibration resets to the factory trimmed value.
// - Crystal valid stays low until amplitude detector settles.
`timescale 1ns/10ps
module sscs_clock_select #(
  parameter logic [7:0] FACTORY_TRIM = sscs_pkg::FACTORY_TRIM_DEF,
  parameter int SETTLE_CYCLES = sscs_pkg::XTAL_BIAS_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic int_osc_tick,
  input wire logic ext_osc_tick,
  input wire logic xtal_amp_ok,
  output sscs_pkg::sscs_osc_cfg_type osc_cfg,
  output sscs_pkg::sscs_src_type active_src,
  output logic sysclk_tick
);
  import sscs_pkg::*;
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 4095) begin : g_chk
    $error("SETTLE_CYCLES must lie in 1..4095");
  end
  // ****************************************
  // Bus slave
  // ****************************************
  logic aw_got_reg, w_got_reg;
  logic [7:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [2:0] int_ctrl_reg;
  logic [7:0] int_cal_reg;
  logic [3:0] ext_ctrl_reg;
  logic [1:0] src_sel_reg;
  logic [1:0] cur_div_reg;
  logic xvalid_reg;
  logic [11:0] settle_cnt_reg;
  logic [2:0] div_cnt_reg;
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire wr_go = aw_got_reg && w_got_reg && !s_axi_bvalid;
  wire wr_lane = wr_go && wstrb_reg[0];
  wire wr_int_ctrl = wr_lane && waddr_reg == INT_CTRL_OFS;
  wire wr_int_cal = wr_lane && waddr_reg == INT_CAL_OFS;
  wire wr_ext_ctrl = wr_lane && waddr_reg == EXT_CTRL_OFS;
  wire wr_src_sel = wr_lane && waddr_reg == SRC_SEL_OFS;
  wire wr_hit = waddr_reg == INT_CTRL_OFS || waddr_reg == INT_CAL_OFS ||
                waddr_reg == EXT_CTRL_OFS || waddr_reg == SRC_SEL_OFS ||
                waddr_reg == STATUS_OFS;
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire pending;
  logic [31:0] rd_word;
  logic rd_hit;
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      INT_CTRL_OFS: rd_word[2:0] = int_ctrl_reg;
      INT_CAL_OFS: rd_word[7:0] = int_cal_reg;
      EXT_CTRL_OFS: rd_word[7:0] = {xvalid_reg, 3'h0, ext_ctrl_reg};
      SRC_SEL_OFS: rd_word[1:0] = src_sel_reg;
      STATUS_OFS: rd_word[4:0] = {pending, cur_div_reg, active_src};
      default: rd_hit = 1'b0;
    endcase
  end
  // Address and data may arrive in either order; response waits for both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      waddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_got_reg && !aw_fire && !s_axi_bvalid && !wr_go;
      s_axi_wready <= !w_got_reg && !w_fire && !s_axi_bvalid && !wr_go;
      if (aw_fire) begin
        aw_got_reg <= 1'b1;
        waddr_reg <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_fire;
      if (ar_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  // Trim is not range checked; software keeps the frequency legal
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_ctrl_reg <= {INT_EN_RESET, DIV_RESET};
      int_cal_reg <= FACTORY_TRIM;
      ext_ctrl_reg <= {1'b0, DRIVE_RESET};
      src_sel_reg <= SRC_SCALED;
    end else begin
      if (wr_int_ctrl) begin
        int_ctrl_reg <= wdata_reg[2:0];
      end
      if (wr_int_cal) begin
        int_cal_reg <= wdata_reg[7:0];
      end
      if (wr_ext_ctrl) begin
        ext_ctrl_reg <= wdata_reg[3:0];
      end
      if (wr_src_sel) begin
        src_sel_reg <= wdata_reg[1:0];
      end
    end
  end

  wire int_en = int_ctrl_reg[INT_EN_BIT];
  wire ext_en = ext_ctrl_reg[EXT_EN_BIT];
  // Copy shows reset values too, so the oscillator runs through reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_cfg <= '{INT_EN_RESET, DIV_RESET, FACTORY_TRIM, 1'b0, DRIVE_RESET};
    end else begin
      osc_cfg.int_en <= int_en;
      osc_cfg.internal_clock_divide_select <= int_ctrl_reg[1:0];
      osc_cfg.int_trim <= int_cal_reg;
      osc_cfg.ext_en <= ext_en;
      osc_cfg.external_osc_drive_select <= ext_ctrl_reg[2:0];
    end
  end

  // ****************************************
  // Crystal valid detection
  // ****************************************
  // Any amplitude drop restarts the settling wait
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_cnt_reg <= 12'h000;
      xvalid_reg <= 1'b0;
    end else if (!ext_en || !xtal_amp_ok) begin
      settle_cnt_reg <= 12'h000;
      xvalid_reg <= 1'b0;
    end else if (settle_cnt_reg == 12'(SETTLE_CYCLES - 1)) begin
      xvalid_reg <= 1'b1;
    end else begin
      settle_cnt_reg <= settle_cnt_reg + 12'h001;
    end
  end

  // ****************************************
  // Source mux and divider
  // ****************************************
  wire int_tick = int_osc_tick && int_en;
  wire ext_tick = ext_osc_tick && ext_en;
  wire [2:0] div_mask = 3'((4'h1 << cur_div_reg) - 4'h1);
  logic tick_next;
  always_comb begin
    case (active_src)
      SRC_SCALED: tick_next = int_tick && div_cnt_reg == div_mask;
      SRC_DIRECT: tick_next = int_tick;
      SRC_EXT: tick_next = ext_tick;
      default: tick_next = 1'b0;
    endcase
  end
  // A stopped source would never finish its cycle; let it switch at once
  wire src_idle = active_src == SRC_EXT ? !ext_en : !int_en;
  wire sel_legal = src_sel_reg != 2'b11;
  assign pending = sel_legal && (src_sel_reg != active_src ||
                   int_ctrl_reg[1:0] != cur_div_reg);
  wire switch_ok = pending && (tick_next || src_idle);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_src <= SRC_SCALED;
      cur_div_reg <= DIV_RESET;
      div_cnt_reg <= 3'h0;
      sysclk_tick <= 1'b0;
    end else begin
      sysclk_tick <= tick_next;
      if (switch_ok) begin
        active_src <= sscs_src_type'(src_sel_reg);
        cur_div_reg <= int_ctrl_reg[1:0];
        div_cnt_reg <= 3'h0;
      end else if (int_tick) begin
        div_cnt_reg <= div_cnt_reg == div_mask ? 3'h0 : div_cnt_reg + 3'h1;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_reset_src;
    $rose(aresetn) |-> active_src == SRC_SCALED && cur_div_reg == 2'h3;
  endproperty
  a_reset_src: assert property (p_reset_src)
    else $error("reset did not select scaled internal oscillator");
  property p_reset_div;
    $rose(aresetn) |-> int_ctrl_reg == 3'h7 && osc_cfg.int_en == 1'b1 &&
      osc_cfg.internal_clock_divide_select == 2'h3;
  endproperty
  a_reset_div: assert property (p_reset_div)
    else $error("divider field not divide by eight after reset");
  property p_reset_trim;
    $rose(aresetn) |-> int_cal_reg == FACTORY_TRIM ##1 1'b1 ##1
      osc_cfg.int_trim == FACTORY_TRIM || $past(wr_int_cal, 2);
  endproperty
  a_reset_trim: assert property (p_reset_trim)
    else $error("trim not loaded with factory value");
  property p_scaled_tick;
    sysclk_tick && $past(active_src) == SRC_SCALED |->
      $past(int_tick) && $past(div_cnt_reg) == $past(div_mask);
  endproperty
  a_scaled_tick: assert property (p_scaled_tick)
    else $error("scaled clock edge off divider boundary");
  property p_ext_tick;
    sysclk_tick && $past(active_src) == SRC_EXT |-> $past(ext_tick);
  endproperty
  a_ext_tick: assert property (p_ext_tick)
    else $error("external source edge without crystal edge");
  property p_enable_write;
    wr_int_ctrl |=> int_ctrl_reg[INT_EN_BIT] == $past(wdata_reg[2])
      ##1 osc_cfg.int_en == $past(wdata_reg[2], 2);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("oscillator enable did not follow write");
  property p_valid_settle;
    $rose(xvalid_reg) |-> $past(ext_en) && $past(xtal_amp_ok) &&
      $past(settle_cnt_reg) == 12'(SETTLE_CYCLES - 1);
  endproperty
  a_valid_settle: assert property (p_valid_settle)
    else $error("crystal valid rose before settling");
  property p_clean_switch;
    $changed(active_src) || $changed(cur_div_reg) |->
      $past(tick_next) || $past(src_idle);
  endproperty
  a_clean_switch: assert property (p_clean_switch)
    else $error("clock switch cut a system clock cycle short");
endmodule

// ---- testbench/sscs_crystal_model.sv ----
// Purpose: Behavioural crystal and amplitude detector on the far side.
// Assumes: One-cycle ticks on aclk stand for crystal edges.
// Notes: Oscillates only once biased; stands still while disabled.
`timescale 1ns/10ps
module sscs_crystal_model #(
  parameter int PERIOD = 3,
  parameter int BIAS_CYC = 40,
  parameter logic [2:0] DRIVE_NEED = 3'h7
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ext_en,
  input wire logic [2:0] drive,
  input wire logic slow,
  output logic amp_ok,
  output logic osc_tick
);
  int bias_cnt;
  int ph_cnt;
  // Wrong drive code never builds amplitude
  wire logic pumping = ext_en && (drive == DRIVE_NEED);
  int bias_lim;
  assign bias_lim = slow ? 4 * BIAS_CYC : BIAS_CYC;
  always_ff @(posedge aclk) begin
    if (!aresetn || !pumping) begin
      bias_cnt <= 0;
      amp_ok <= 1'b0;
    end else if (bias_cnt < bias_lim) begin
      bias_cnt <= bias_cnt + 1;
    end else begin
      amp_ok <= 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!amp_ok) begin
      ph_cnt <= 0;
    end else begin
      ph_cnt <= (ph_cnt == PERIOD - 1) ? 0 : ph_cnt + 1;
    end
    osc_tick <= amp_ok && (ph_cnt == PERIOD - 1);
  end
endmodule

// ---- testbench/tb_top.sv ----
// Purpose: Self-checking bench for the system clock source select.
// Assumes: Internal oscillator edge every second aclk cycle.
// Notes: Crystal valid settle shortened to 4 cycles.
`timescale 1ns/10ps
module tb_top;
  import sscs_pkg::*;
  localparam logic [7:0] TRIM = 8'h5C;
  localparam int XPER = 3;
  localparam int WAIT_1MS = 1000000 / CLK_PERIOD_NS;
  localparam logic [31:0] INT_CTRL_RST =
    (32'(INT_EN_RESET) << INT_EN_BIT) | 32'(DIV_RESET);
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic int_tick = 1'b0;
  logic slow = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, sys_tick, amp_ok, ext_tick;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  sscs_osc_cfg_type cfg;
  sscs_src_type src;
  wire logic [1:0] cfg_div = cfg.internal_clock_divide_select;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  sscs_clock_select #(.FACTORY_TRIM(TRIM), .SETTLE_CYCLES(4))
  sscs_clock_select_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .int_osc_tick(int_tick),
    .ext_osc_tick(ext_tick), .xtal_amp_ok(amp_ok), .osc_cfg(cfg),
    .active_src(src), .sysclk_tick(sys_tick));
  sscs_crystal_model #(.PERIOD(XPER)) sscs_crystal_model_inst (.aclk(aclk),
    .aresetn(aresetn), .ext_en(cfg.ext_en),
    .drive(cfg.external_osc_drive_select), .slow(slow), .amp_ok(amp_ok),
    .osc_tick(ext_tick));
  // ****************************************
  // Clock, oscillator ticks, timeout
  // ****************************************
  always #25 aclk = ~aclk;
  always @(posedge aclk) begin
    int_tick <= ~int_tick;
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task check(input string what, input logic [31:0] exp,
             input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  task gap(output int g);
    g = 0;
    @(negedge aclk iff sys_tick);
    do begin
      @(negedge aclk);
      g++;
    end while (!sys_tick);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    logic [31:0] d;
    logic [1:0] r;
    rd(INT_CTRL_OFS, d, r);
    check("int ctrl", INT_CTRL_RST, d);
    rd(INT_CAL_OFS, d, r);
    check("trim", 32'(TRIM), d);
    rd(STATUS_OFS, d, r);
    check("status", 32'(DIV_RESET) << ACT_DIV_LSB, d);
    check("source", 32'(SRC_SCALED), 32'(src));
    $display("reset test done");
  endtask
  task t_unmapped;
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h20, 32'hFF, r);
    check("write resp", 32'(RESP_SLVERR), 32'(r));
    rd(8'h20, d, r);
    check("read resp", 32'(RESP_SLVERR), 32'(r));
    check("read data", 32'h0, d);
    $display("unmapped test done");
  endtask
  task t_trim;
    logic [31:0] d;
    logic [1:0] r;
    wr(INT_CAL_OFS, 32'h5A, r); // Stays well under the ceiling
    rd(INT_CAL_OFS, d, r);
    check("trim back", 32'h5A, d);
    check("trim out", 32'h5A, 32'(cfg.int_trim));
    wr(INT_CTRL_OFS, 32'(DIV_RESET), r);
    @(negedge aclk);
    check("int off", 32'h0, 32'(cfg.int_en));
    wr(INT_CTRL_OFS, (32'h1 << INT_EN_BIT) | 32'(DIV_RESET), r);
    @(negedge aclk);
    check("int on", 32'h1, 32'(cfg.int_en));
    $display("trim test done");
  endtask
  task t_divide;
    logic [1:0] r;
    int g;
    for (int d = 0; d < 4; d++) begin
      wr(INT_CTRL_OFS, (32'h1 << INT_EN_BIT) | 32'(d), r);
      repeat (3) gap(g);
      check("scaled period", 32'(2 << d), 32'(g));
      check("divide out", 32'(d), 32'(cfg_div));
    end
    $display("divide test done");
  endtask
  task t_direct;
    logic [1:0] r;
    int g;
    wr(SRC_SEL_OFS, 32'(SRC_DIRECT), r);
    repeat (3) gap(g);
    check("direct src", 32'(SRC_DIRECT), 32'(src));
    check("direct period", 32'h2, 32'(g));
    $display("direct test done");
  endtask
  task t_crystal;
    logic [31:0] d;
    logic [1:0] r;
    int g;
    int n;
    // Pins parked low then analog first; no pins in this model
    wr(EXT_CTRL_OFS, (32'h1 << EXT_EN_BIT) | 32'h7, r);
    rd(EXT_CTRL_OFS, d, r);
    check("valid early", 32'h0, 32'(d[XVALID_BIT]));
    repeat (WAIT_1MS) @(posedge aclk);
    n = 0;
    do begin
      rd(EXT_CTRL_OFS, d, r);
      n++;
    end while (!d[XVALID_BIT] && n < 50);
    check("valid late", 32'h1, 32'(d[XVALID_BIT]));
    wr(SRC_SEL_OFS, 32'(SRC_EXT), r);
    repeat (3) gap(g);
    check("ext src", 32'(SRC_EXT), 32'(src));
    check("ext period", 32'(XPER), 32'(g));
    $display("crystal test done");
  endtask
  task t_rereset;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    @(negedge aclk);
    check("src again", 32'(SRC_SCALED), 32'(src));
    check("int on again", 32'(INT_EN_RESET), 32'(cfg.int_en));
    check("cfg div again", 32'(DIV_RESET), 32'(cfg_div));
    rd(INT_CTRL_OFS, d, r);
    check("int ctrl again", INT_CTRL_RST, d);
    rd(EXT_CTRL_OFS, d, r);
    check("ext ctrl again", 32'h0, d);
    $display("second reset test done");
  endtask
  task tally_and_finish;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_unmapped();
    t_trim();
    t_divide();
    t_direct();
    t_crystal();
    t_rereset();
    tally_and_finish();
  end
endmodule
